// *** hdl/ddc_pkg.sv ***
// constants shared by the down converter top and its decimation paths
// assumes a single 100 MHz clock and an APB register port with 32-bit data
package down_converter_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned STAGES = 5;
  localparam int unsigned ACC_W = 91; // sample width plus five times log2 of the largest decimation
  localparam int unsigned SHIFT_W = 7;
  localparam int unsigned SCALE_W = 16;
  localparam int unsigned FRAC_W = 15;
  localparam int unsigned PHASE_W = 32;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DECIM_OFF = 8'h04;
  localparam logic [7:0] SHIFT_OFF = 8'h08;
  localparam logic [7:0] SCALE_OFF = 8'h0C;
  localparam logic [7:0] PHASE_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_REAL_BIT = 1;
  localparam logic [15:0] DECIM_RST = 16'h0010;
  localparam logic [15:0] DECIM_MIN = 16'h0010;
  localparam logic [15:0] DECIM_MAX = 16'h8000;
  localparam logic [6:0] SHIFT_RST = 7'h37;
  localparam logic [6:0] SHIFT_MAX = 7'h4B;
  localparam logic [15:0] SCALE_RST = 16'h8000;
  localparam logic [31:0] PHASE_RST = 32'h0000_0000;
  localparam logic [2:0] FIR_DECIM_QUAD = 3'h4;
  localparam logic [2:0] FIR_DECIM_REAL = 3'h2;
endpackage

// *** hdl/path_if.sv ***
// carrier between the converter top and one decimation path
// assumes both ends sit in the pclk domain
`timescale 1ns/1ps
interface path_if;
  import down_converter_pkg::*;
  logic signed [SAMPLE_W-1:0] sample;
  logic sample_valid;
  logic dump;
  logic [SHIFT_W-1:0] shift;
  logic [SCALE_W-1:0] scale;
  logic signed [SAMPLE_W-1:0] result;
  logic result_valid;
  modport ctrl (output sample, sample_valid, dump, shift, scale, input result, result_valid);
  modport path (input sample, sample_valid, dump, shift, scale, output result, result_valid);
endinterface

// *** hdl/decim_path.sv ***
// one real decimation path: input shifter, fifth-order comb filter, scaling multiplier
// assumes dump is a one-cycle pulse once every R accepted samples
`timescale 1ns/1ps
module decim_path
  import down_converter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  path_if.path p
);
  logic signed [ACC_W-1:0] integ_q [STAGES];
  logic signed [ACC_W-1:0] integ_d [STAGES];
  logic signed [ACC_W-1:0] dly_q [STAGES];
  logic signed [ACC_W-1:0] dly_d [STAGES];
  logic signed [ACC_W-1:0] comb [STAGES+1];
  logic signed [ACC_W-1:0] in_ext;
  logic signed [SAMPLE_W-1:0] top;
  logic signed [SCALE_W+SAMPLE_W:0] prod;
  logic signed [SAMPLE_W+1:0] scaled;
  logic signed [SAMPLE_W-1:0] res_q;
  logic signed [SAMPLE_W-1:0] res_d;
  logic vld_q;
  logic vld_d;

  // ****************************************
  // filter next state
  // ****************************************
  always_comb
  begin
    // input placed shift bits above the filter lsb
    in_ext = ACC_W'(p.sample) <<< p.shift;
    comb[0] = integ_q[STAGES-1];
    // integrators at the full rate: the first takes the shifted input, the rest the stage before
    integ_d[0] = p.sample_valid ? integ_q[0] + in_ext : integ_q[0];
    for (int k = 1; k < STAGES; k++)
    begin
      integ_d[k] = p.sample_valid ? integ_q[k] + integ_q[k-1] : integ_q[k];
    end
    // combs at the decimated rate
    for (int k = 0; k < STAGES; k++)
    begin
      comb[k+1] = comb[k] - dly_q[k];
      dly_d[k] = p.dump ? comb[k] : dly_q[k];
    end
    // output msb aligned to the bus msb
    top = comb[STAGES][ACC_W-1 -: SAMPLE_W];
    // unsigned 1.15 factor, whole field usable
    prod = top * $signed({1'b0, p.scale});
    scaled = prod[SCALE_W+SAMPLE_W:FRAC_W];
    res_d = res_q;
    vld_d = p.dump;
    if (p.dump)
    begin
      // saturate the scaled value to the output width
      if (scaled[SAMPLE_W+1:SAMPLE_W-1] != {3{scaled[SAMPLE_W-1]}})
      begin
        res_d = scaled[SAMPLE_W+1] ? 16'h8000 : 16'h7FFF;
      end
      else
      begin
        res_d = scaled[SAMPLE_W-1:0];
      end
    end
  end

  // ****************************************
  // filter registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < STAGES; k++)
      begin
        integ_q[k] <= '0;
        dly_q[k] <= '0;
      end
      res_q <= '0;
      vld_q <= 1'b0;
    end
    else
    begin
      integ_q <= integ_d;
      dly_q <= dly_d;
      res_q <= res_d;
      vld_q <= vld_d;
    end
  end

  assign p.result = res_q;
  assign p.result_valid = vld_q;
endmodule

// *** hdl/down_converter.sv ***
// down converter core: local oscillator mixer, two decimation paths, shaping stage
// decimator and APB register slave; samples arrive from an external zero-stuffing expander
// assumes one pclk domain and inputs synchronous to pclk
//
// What this block does
// - mixes each sample with sine and cosine a quarter cycle apart.
// - quadrature mode shaping stage decimates by four, totals multiply.
// - fifth-order comb filter, gain R to the fifth, inverse compensated.
// - power-of-two part by input shift, remainder by output multiplier.
// - shift aligns the filter output msb with the output bus msb.
// - shift is the distance between input lsb and filter lsb.
// - with correct shift the multiplier input lies in (0.5, 1].
// - scale field takes values from 0 to 2 minus 2^-15.
// - filter decimation R programmable from 16 to 32768.
// - real output mode shaping stage decimates by two.
`timescale 1ns/1ps
module down_converter
  import down_converter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid,
  output logic signed [SAMPLE_W-1:0] i_out,
  output logic signed [SAMPLE_W-1:0] q_out,
  output logic out_valid
);
  path_if ip ();
  path_if qp ();

  logic en_q, en_d, real_q, real_d;
  logic [15:0] decim_q, decim_d;
  logic [SHIFT_W-1:0] shift_q, shift_d;
  logic [SCALE_W-1:0] scale_q, scale_d;
  logic [PHASE_W-1:0] inc_q, inc_d, phase_q, phase_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic signed [SAMPLE_W-1:0] mix_i_q, mix_i_d, mix_q_q, mix_q_d;
  logic mix_v_q, mix_v_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0] fir_q, fir_d;
  logic [15:0] outcnt_q, outcnt_d;
  logic signed [SAMPLE_W-1:0] iout_q, iout_d, qout_q, qout_d;
  logic ov_q, ov_d;
  logic signed [2*SAMPLE_W-1:0] prod_i, prod_q;
  logic [2:0] fir_lim;
  logic dump;
  logic wr_done;
  logic rd_take;

  // quarter-wave table of the oscillator, sixteen points per cycle
  function automatic logic signed [SAMPLE_W-1:0] osc_sine(input logic [3:0] idx);
    logic signed [SAMPLE_W-1:0] v;
    v = 16'h0000;
    case (idx[1:0])
      2'h0: v = idx[2] ? 16'h7FFF : 16'h0000;
      2'h1: v = idx[2] ? 16'h7642 : 16'h30FB;
      2'h2: v = 16'h5A82;
      default: v = idx[2] ? 16'h30FB : 16'h7642;
    endcase
    return idx[3] ? -v : v;
  endfunction

  // ****************************************
  // register bus
  // ****************************************
  assign rd_take = psel && penable && !pready_q;
  assign wr_done = psel && penable && pready_q && pwrite;

  // answer one cycle into the access phase; writes land at completion
  always_comb
  begin
    pready_d = rd_take;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    en_d = en_q;
    real_d = real_q;
    decim_d = decim_q;
    shift_d = shift_q;
    scale_d = scale_q;
    inc_d = inc_q;
    if (rd_take)
    begin
      prdata_d = 32'h0000_0000;
      if (paddr == CTRL_OFF)
      begin
        prdata_d[CTRL_EN_BIT] = en_q;
        prdata_d[CTRL_REAL_BIT] = real_q;
      end
      else if (paddr == DECIM_OFF)
        prdata_d[15:0] = decim_q;
      else if (paddr == SHIFT_OFF)
        prdata_d[SHIFT_W-1:0] = shift_q;
      else if (paddr == SCALE_OFF)
        prdata_d[SCALE_W-1:0] = scale_q;
      else if (paddr == PHASE_OFF)
        prdata_d = inc_q;
      else if (paddr == STATUS_OFF)
        prdata_d = {15'h0000, ov_q, outcnt_q};
      else
        pslverr_d = 1'b1;
    end
    if (wr_done)
    begin
      if (paddr == CTRL_OFF)
      begin
        en_d = pwdata[CTRL_EN_BIT];
        real_d = pwdata[CTRL_REAL_BIT];
      end
      else if (paddr == DECIM_OFF)
      begin
        // keep R inside its legal range
        if (pwdata < 32'(DECIM_MIN))
          decim_d = DECIM_MIN;
        else if (pwdata > 32'(DECIM_MAX))
          decim_d = DECIM_MAX;
        else
          decim_d = pwdata[15:0];
      end
      else if (paddr == SHIFT_OFF)
        shift_d = (pwdata > 32'(SHIFT_MAX)) ? SHIFT_MAX : pwdata[SHIFT_W-1:0];
      else if (paddr == SCALE_OFF)
        scale_d = pwdata[SCALE_W-1:0];
      else if (paddr == PHASE_OFF)
        inc_d = pwdata;
    end
  end

  // ****************************************
  // mixer and decimation control
  // ****************************************
  assign prod_i = sample_in * osc_sine(phase_q[PHASE_W-1 -: 4] + 4'h4);
  assign prod_q = sample_in * osc_sine(phase_q[PHASE_W-1 -: 4]);
  assign dump = mix_v_q && (cnt_q == decim_q - 16'h0001);
  assign fir_lim = real_q ? FIR_DECIM_REAL : FIR_DECIM_QUAD;

  // one product per clock, cosine leads sine by a quarter cycle
  always_comb
  begin
    phase_d = phase_q;
    mix_i_d = mix_i_q;
    mix_q_d = mix_q_q;
    mix_v_d = en_q && sample_valid;
    if (en_q && sample_valid)
    begin
      phase_d = phase_q + inc_q;
      mix_i_d = prod_i[2*SAMPLE_W-2 -: SAMPLE_W];
      mix_q_d = prod_q[2*SAMPLE_W-2 -: SAMPLE_W];
    end
    cnt_d = cnt_q;
    if (mix_v_q)
      cnt_d = dump ? 16'h0000 : cnt_q + 16'h0001;
    // shaping stage keeps one of every fir_lim filter outputs
    fir_d = fir_q;
    iout_d = iout_q;
    qout_d = qout_q;
    outcnt_d = outcnt_q;
    ov_d = ov_q;
    if (ip.result_valid)
    begin
      if (fir_q >= fir_lim - 3'h1)
      begin
        fir_d = 3'h0;
        iout_d = ip.result;
        qout_d = qp.result;
        outcnt_d = outcnt_q + 16'h0001;
        ov_d = ov_q || (outcnt_q == 16'hFFFF);
      end
      else
        fir_d = fir_q + 3'h1;
    end
    if (!en_q)
    begin
      cnt_d = 16'h0000;
      fir_d = 3'h0;
    end
  end

  assign ip.sample = mix_i_q;
  assign qp.sample = mix_q_q;
  assign ip.sample_valid = mix_v_q;
  assign qp.sample_valid = mix_v_q;
  assign ip.dump = dump;
  assign qp.dump = dump;
  assign ip.shift = shift_q;
  assign qp.shift = shift_q;
  assign ip.scale = scale_q;
  assign qp.scale = scale_q;

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      real_q <= 1'b0;
      decim_q <= DECIM_RST;
      shift_q <= SHIFT_RST;
      scale_q <= SCALE_RST;
      inc_q <= PHASE_RST;
      phase_q <= PHASE_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      mix_i_q <= '0;
      mix_q_q <= '0;
      mix_v_q <= 1'b0;
      cnt_q <= 16'h0000;
      fir_q <= 3'h0;
      outcnt_q <= 16'h0000;
      ov_q <= 1'b0;
      iout_q <= '0;
      qout_q <= '0;
      out_valid <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      real_q <= real_d;
      decim_q <= decim_d;
      shift_q <= shift_d;
      scale_q <= scale_d;
      inc_q <= inc_d;
      phase_q <= phase_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      mix_i_q <= mix_i_d;
      mix_q_q <= mix_q_d;
      mix_v_q <= mix_v_d;
      cnt_q <= cnt_d;
      fir_q <= fir_d;
      outcnt_q <= outcnt_d;
      ov_q <= ov_d;
      iout_q <= iout_d;
      qout_q <= qout_d;
      out_valid <= ip.result_valid && (fir_q >= fir_lim - 3'h1);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign i_out = iout_q;
  assign q_out = qout_q;

  // ****************************************
  // decimation paths
  // ****************************************
  decim_path u_path_i (
    .pclk(pclk),
    .presetn(presetn),
    .p(ip.path)
  );

  decim_path u_path_q (
    .pclk(pclk),
    .presetn(presetn),
    .p(qp.path)
  );
endmodule

// *** sim/expander_src.sv ***
// zero-stuffing sample source in front of the down converter
// assumes pclk domain; factor is at least 1 and held while run is high
`timescale 1ns/1ps
module expander_src
  import down_converter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [7:0] factor,
  input wire logic signed [SAMPLE_W-1:0] level,
  output logic signed [SAMPLE_W-1:0] sample,
  output logic sample_valid
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // divide-by-factor counter, wraps at factor-1
  always_comb
  begin
    cnt_d = (cnt_q >= factor - 8'h01) ? 8'h00 : cnt_q + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end

  // one real sample per factor clocks, zeros between, junk when stopped
  assign sample = !run ? ~level : (cnt_q == 8'h00) ? level : '0;
  assign sample_valid = run;
endmodule

// *** sim/down_converter_checker.sv ***
// port checker for the down converter: bus handshake and output stream
// assumes binding to down_converter in the single pclk domain
`timescale 1ns/1ps
module down_converter_checker
  import down_converter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] i_out,
  input wire logic signed [SAMPLE_W-1:0] q_out,
  input wire logic out_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // address decodes to a register
  wire mapped = (paddr <= STATUS_OFF) && (paddr[1:0] == 2'b00);

  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pready && !mapped |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access without error");
  property p_ok; pready && mapped |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("error on mapped access");
  property p_rd0; pready && pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_rd0: assert property (p_rd0) else $error("error read data not zero");
  property p_gap; out_valid |=> (!out_valid) [*8]; endproperty
  a_gap: assert property (p_gap) else $error("outputs too close");
  property p_hold; !out_valid |-> $stable(i_out) && $stable(q_out); endproperty
  a_hold: assert property (p_hold) else $error("output moved without strobe");
  property p_idle; (!sample_valid) [*8] |-> !out_valid; endproperty
  a_idle: assert property (p_idle) else $error("output without samples");

  c_out: cover property (out_valid);
  c_err: cover property (pready && pslverr);
  c_wr: cover property (pready && pwrite && mapped);
endmodule

bind down_converter down_converter_checker u_down_converter_checker (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sample_valid, .i_out,
  .q_out, .out_valid);

// *** sim/testbench.sv ***
// self-checking bench for the down converter with a zero-stuffing source
// assumes 100 MHz pclk and an APB master with one request at a time
`timescale 1ns/1ps
module testbench;
  import down_converter_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run = 1'b0;
  logic [7:0] factor = 8'h01;
  logic signed [SAMPLE_W-1:0] level = '0;
  logic signed [SAMPLE_W-1:0] sample;
  logic sample_valid;
  logic signed [SAMPLE_W-1:0] i_out;
  logic signed [SAMPLE_W-1:0] q_out;
  logic out_valid;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int checked = 0;
  int gap;

  // ****
  // clock, instances, helpers
  // ****
  always #5 pclk = ~pclk;
  down_converter u_down_converter (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sample_in(sample), .sample_valid, .i_out,
    .q_out, .out_valid);
  expander_src u_expander_src (.pclk, .presetn, .run, .factor, .level, .sample,
    .sample_valid);

  task automatic finish_test;
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one bus transfer, held until ready, then released for a cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 20)
    begin
      error_cnt++;
      finish_test();
    end
  endtask

  // waits for the next output strobe, counting cycles in gap
  task automatic wait_out;
    gap = 0;
    do
    begin
      @(posedge pclk);
      gap++;
    end while (out_valid !== 1'b1 && gap < 2000);
    if (gap == 2000)
    begin
      error_cnt++;
      finish_test();
    end
  endtask

  // ****
  // scenarios
  // ****
  // reset values, unmapped place, clamped and full-range writes
  task automatic t_regs;
    logic [7:0] a [6] = '{CTRL_OFF, DECIM_OFF, SHIFT_OFF, SCALE_OFF, PHASE_OFF, STATUS_OFF};
    logic [31:0] e [6] = '{32'h0000_0000, 32'(DECIM_RST), 32'(SHIFT_RST), 32'(SCALE_RST),
      PHASE_RST, 32'h0000_0000};
    logic [7:0] wa [4] = '{DECIM_OFF, DECIM_OFF, SHIFT_OFF, SCALE_OFF};
    logic [31:0] wd [4] = '{32'h0000_0005, 32'h0000_FFFF, 32'h0000_007F, 32'h0000_FFFF};
    logic [31:0] we [4] = '{32'(DECIM_MIN), 32'(DECIM_MAX), 32'(SHIFT_MAX), 32'h0000_FFFF};
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b0, a[k], 32'h0000_0000);
      check(rd, e[k], "reset value");
    end
    apb(1'b1, 8'h18, 32'h0000_1234);
    check(err, 1'b1, "write error");
    apb(1'b0, 8'h18, 32'h0000_0000);
    check(err, 1'b1, "read error");
    check(rd, 32'h0000_0000, "error read data");
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, wa[k], wd[k]);
      apb(1'b0, wa[k], 32'h0000_0000);
      check(rd, we[k], "clamped value");
    end
  endtask

  // DC level through mixer, filter, shift and scale
  task automatic t_gain;
    logic [7:0] l [5] = '{8'h01, 8'h08, 8'h08, 8'h01, 8'h01};
    logic [6:0] sh [5] = '{7'h37, 7'h3A, 7'h37, 7'h37, 7'h37};
    logic [15:0] sc [5] = '{16'h8000, 16'h8000, 16'h8000, 16'h4000, 16'hFFFF};
    logic signed [15:0] x [5] = '{16'h1388, 16'h1388, 16'h1388, 16'hE890, 16'h7530};
    logic signed [15:0] min_v [5] = '{16'h137E, 16'h137E, 16'h026C, 16'hF444, 16'h7FFF};
    logic signed [15:0] max_v [5] = '{16'h1388, 16'h1388, 16'h0271, 16'hF44C, 16'h7FFF};
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, CTRL_OFF, 32'h0000_0000);
      factor <= l[k];
      level <= x[k];
      run <= 1'b1;
      apb(1'b1, DECIM_OFF, 32'h0000_0010);
      apb(1'b1, SHIFT_OFF, 32'(sh[k]));
      apb(1'b1, SCALE_OFF, 32'(sc[k]));
      apb(1'b1, CTRL_OFF, 32'h0000_0001);
      repeat (3) wait_out();
      check(i_out >= min_v[k] && i_out <= max_v[k], 1'b1, "i_out");
      check(q_out, 32'h0000_0000, "q_out");
    end
  endtask

  // rotating oscillator, one turn per sixteen samples, averages a DC level out
  task automatic t_mix;
    apb(1'b1, CTRL_OFF, 32'h0000_0000);
    factor <= 8'h01;
    level <= 16'sh4000;
    apb(1'b1, DECIM_OFF, 32'h0000_0010);
    apb(1'b1, SHIFT_OFF, 32'h0000_0037);
    apb(1'b1, SCALE_OFF, 32'h0000_8000);
    apb(1'b1, PHASE_OFF, 32'h1000_0000);
    apb(1'b0, PHASE_OFF, 32'h0000_0000);
    check(rd, 32'h1000_0000, "phase step");
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    repeat (3) wait_out();
    check(i_out >= 16'shFFFE && i_out <= 16'sh0002, 1'b1, "rotating i_out");
    check(q_out >= 16'shFFFE && q_out <= 16'sh0002, 1'b1, "rotating q_out");
    apb(1'b1, PHASE_OFF, 32'h0000_0000);
  endtask

  // output spacing for both modes and a non-minimum R
  task automatic t_period;
    logic [31:0] c [3] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0001};
    logic [31:0] r [3] = '{32'h0000_0010, 32'h0000_0010, 32'h0000_0014};
    int cyc [3] = '{64, 32, 80};
    logic [31:0] st;
    factor <= 8'h01;
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, CTRL_OFF, 32'h0000_0000);
      apb(1'b1, DECIM_OFF, r[k]);
      apb(1'b1, CTRL_OFF, c[k]);
      repeat (2) wait_out();
      wait_out();
      check(gap, cyc[k], "output spacing");
    end
    // status counts exactly one more output after the next strobe
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    st = rd;
    wait_out();
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    check(rd - st, 32'h0000_0001, "output count");
  endtask

  // stopped source must give no output
  task automatic t_idle;
    int n;
    n = 0;
    run <= 1'b0;
    repeat (10) @(posedge pclk);
    repeat (200)
    begin
      @(posedge pclk);
      n += (out_valid !== 1'b0);
    end
    check(n, 0, "idle strobes");
    run <= 1'b1;
  endtask

  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_gain();
    t_mix();
    t_period();
    t_idle();
    finish_test();
  end
endmodule
